// ===== async_timer_event_wake_tuner.sv
// Timer events, interrupts, wake, shutdown retention and tuner
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "async_timer_consts.svh"
module async_timer_event_wake_tuner
  import async_timer_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output var  logic [31:0] rdata,
  // Prescaler source clock pin and power manager
  input  wire logic        prsc_clk_pin,
  input  wire logic        shutdown_exit,
  // Interrupt requests
  output var  logic        irq_ovf,
  output var  logic        irq_per,
  output var  logic        irq_alarm,
  output var  logic        irq_clock_switch_done,
  output var  logic        irq_ready,
  // Peripheral events
  output var  logic        ev_ovf,
  output var  logic        ev_periodic_flag_0,
  output var  logic        ev_periodic_flag_1,
  output var  logic        ev_alarm_match_flag_0,
  output var  logic        ev_alarm_match_flag_1,
  // Sleep controller
  output var  logic        wake_req
);

  timer_state_t state_reg;
  timer_state_t state_next;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic        busy;
  logic        clock_switch_pending;
  logic        tick;
  logic        tune_hit;
  logic [1:0]  step;
  logic [31:0] pnew;
  logic [31:0] cv_inc;
  logic [31:0] period;
  logic        cnt_tick;
  logic [1:0]  per_set;
  logic [1:0]  alm_hit;
  logic        ovf_set;
  logic        sync_wr;
  logic [31:0] set_mask;
  logic [31:0] clr_mask;
  logic [31:0] sr_view;

  // Tuner period: ceil(256/value) shifted by exponent
  function automatic logic [31:0] tune_period(input logic [7:0] v,
                                              input logic [4:0] e);
    logic [15:0] c;
    c = 16'h0000;
    if (v != 8'h00)
    begin
      c = (16'h0100 + {8'h00, v} - 16'h0001) / {8'h00, v};
    end
    return {16'h0000, c} << e;
  endfunction : tune_period

  // Registers whose writes pass through synchronisation
  function automatic logic is_sync_reg(input logic [7:0] a);
    logic r;
    r = 1'b0;
    if (a == `OFF_CR || a == `OFF_CV || a == `OFF_SCR ||
        a == `OFF_WER || a == `OFF_EVE || a == `OFF_EVD ||
        a == `OFF_PIR0 || a == `OFF_PIR1 || a == `OFF_AR0 ||
        a == `OFF_AR1 || a == `OFF_DTR)
    begin
      r = 1'b1;
    end
    return r;
  endfunction : is_sync_reg

  always_comb
  begin
    state_next = state_reg;
    busy       = (state_reg.busy_cnt != 4'h0);
    clock_switch_pending    = (state_reg.clock_switch_pending_cnt != 4'h0);
    set_mask   = 32'h00000000;
    clr_mask   = 32'h00000000;
    ovf_set    = 1'b0;
    alm_hit    = 2'b00;
    // Pin sampler: level changes once second and third agree
    state_next.s0 = prsc_clk_pin;
    state_next.s1 = state_reg.s0;
    state_next.s2 = state_reg.s1;
    if (state_reg.s1 == state_reg.s2)
    begin
      state_next.lvl = state_reg.s2;
    end
    tick   = state_next.lvl & ~state_reg.lvl & state_reg.en & state_reg.cen;
    period = tune_period(state_reg.dtr_val, state_reg.dtr_exp);
    tune_hit = tick && (state_reg.dtr_val != 8'h00) &&
               (state_reg.tune_cnt >= period - 32'h00000001);
    if (tick)
    begin
      state_next.tune_cnt = tune_hit ? 32'h00000000
                                     : state_reg.tune_cnt + 32'h00000001;
    end
    if (!tick)
    begin
      step = 2'd0;
    end
    else if (!tune_hit)
    begin
      step = 2'd1;
    end
    else
    begin
      step = state_reg.dtr_add ? 2'd2 : 2'd0;
    end
    pnew = state_reg.presc + {30'h00000000, step};
    state_next.presc = pnew;
    // periodic flag on selected bit rise
    per_set[0] = ~state_reg.presc[state_reg.insel0] & pnew[state_reg.insel0];
    per_set[1] = ~state_reg.presc[state_reg.insel1] & pnew[state_reg.insel1];
    cnt_tick   = ~state_reg.presc[state_reg.psel] & pnew[state_reg.psel];
    cv_inc     = state_reg.cv + 32'h00000001;
    if (cnt_tick)
    begin
      alm_hit[0] = (cv_inc == state_reg.ar0);
      alm_hit[1] = (cv_inc == state_reg.ar1);
      state_next.cv = cv_inc;
      // wrap or clearing alarm gives overflow
      if (|(alm_hit & state_reg.ca))
      begin
        state_next.cv = 32'h00000000;
        ovf_set = 1'b1;
      end
      else if (state_reg.cv == 32'hFFFFFFFF)
      begin
        ovf_set = 1'b1;
      end
    end
    sync_wr = wr_en && is_sync_reg(addr) && !busy;
    if (wr_en && (!busy || !is_sync_reg(addr)))
    begin
      if (addr == `OFF_CR)
      begin
        state_next.en   = wdata[`CR_EN];
        state_next.ca   = {wdata[`CR_CA1], wdata[`CR_CA0]};
        state_next.psel = wdata[`CR_PSEL_LSB +: 5];
        if (wdata[`CR_PCLR])
        begin
          state_next.presc = 32'h00000000;
        end
      end
      else if (addr == `OFF_CV)
      begin
        state_next.cv = wdata;
      end
      else if (addr == `OFF_SCR)
      begin
        clr_mask = wdata & `CLR_MASK;
      end
      else if (addr == `OFF_IER)
      begin
        state_next.interrupt_mask_reg = state_reg.interrupt_mask_reg | (wdata & `IRQ_MASK);
      end
      else if (addr == `OFF_IDR)
      begin
        state_next.interrupt_mask_reg = state_reg.interrupt_mask_reg & ~wdata;
      end
      else if (addr == `OFF_WER)
      begin
        state_next.wake_enable_reg = wdata & `SRC_MASK;
      end
      else if (addr == `OFF_AR0)
      begin
        state_next.ar0 = wdata;
      end
      else if (addr == `OFF_AR1)
      begin
        state_next.ar1 = wdata;
      end
      else if (addr == `OFF_PIR0)
      begin
        state_next.insel0 = wdata[4:0];
      end
      else if (addr == `OFF_PIR1)
      begin
        state_next.insel1 = wdata[4:0];
      end
      else if (addr == `OFF_CLOCK)
      begin
        if (!clock_switch_pending && (wdata[`CLOCK_CEN] != state_reg.cen))
        begin
          state_next.cen = wdata[`CLOCK_CEN];
          state_next.clock_switch_pending_cnt = 4'(`CLKSW_CYC);
        end
      end
      else if (addr == `OFF_DTR)
      begin
        state_next.dtr_val = wdata[7:0];
        state_next.dtr_exp = wdata[`DTR_EXP_LSB +: 5];
        state_next.dtr_add = wdata[`DTR_ADD];
      end
      else if (addr == `OFF_EVE)
      begin
        state_next.event_mask_reg = state_reg.event_mask_reg | (wdata & `SRC_MASK);
      end
      else if (addr == `OFF_EVD)
      begin
        state_next.event_mask_reg = state_reg.event_mask_reg & ~wdata;
      end
    end
    if (sync_wr)
    begin
      state_next.busy_cnt = 4'(`SYNC_CYC);
    end
    else if (busy)
    begin
      state_next.busy_cnt = state_reg.busy_cnt - 4'h1;
    end
    if (clock_switch_pending)
    begin
      state_next.clock_switch_pending_cnt = state_reg.clock_switch_pending_cnt - 4'h1;
    end
    // shutdown exit clears interrupt mask only
    if (shutdown_exit)
    begin
      state_next.interrupt_mask_reg = 32'h00000000;
    end
    set_mask[`BIT_OVF]  = ovf_set;
    set_mask[`BIT_ALM0] = alm_hit[0];
    set_mask[`BIT_ALM1] = alm_hit[1];
    set_mask[`BIT_PERIODIC_FLAG_0] = per_set[0];
    set_mask[`BIT_PERIODIC_FLAG_1] = per_set[1];
    set_mask[`BIT_READY]  = busy && (state_next.busy_cnt == 4'h0);
    set_mask[`BIT_CLKRDY] = clock_switch_pending && (state_next.clock_switch_pending_cnt == 4'h0);
    // status held until clear, set wins
    state_next.sr = (state_reg.sr & ~clr_mask) | set_mask;
    // five requests from status and mask
    state_next.irq[0] = state_next.sr[`BIT_OVF] & state_next.interrupt_mask_reg[`BIT_OVF];
    state_next.irq[1] = |(state_next.sr[`BIT_PERIODIC_FLAG_1:`BIT_PERIODIC_FLAG_0] &
                          state_next.interrupt_mask_reg[`BIT_PERIODIC_FLAG_1:`BIT_PERIODIC_FLAG_0]);
    state_next.irq[2] = |(state_next.sr[`BIT_ALM1:`BIT_ALM0] &
                          state_next.interrupt_mask_reg[`BIT_ALM1:`BIT_ALM0]);
    state_next.irq[3] = state_next.sr[`BIT_CLKRDY] &
                        state_next.interrupt_mask_reg[`BIT_CLKRDY];
    state_next.irq[4] = state_next.sr[`BIT_READY] & state_next.interrupt_mask_reg[`BIT_READY];
    state_next.ev = {alm_hit[1] & state_reg.event_mask_reg[`BIT_ALM1],
                     alm_hit[0] & state_reg.event_mask_reg[`BIT_ALM0],
                     per_set[1] & state_reg.event_mask_reg[`BIT_PERIODIC_FLAG_1],
                     per_set[0] & state_reg.event_mask_reg[`BIT_PERIODIC_FLAG_0],
                     ovf_set & state_reg.event_mask_reg[`BIT_OVF]};
    state_next.wake = |(state_next.sr & state_reg.wake_enable_reg & `SRC_MASK);
    sr_view = state_reg.sr;
    sr_view[`BIT_BUSY]    = busy;
    sr_view[`BIT_CLOCK_SWITCH_PENDING] = clock_switch_pending;
    state_next.rdata = 32'h00000000;
    // live count and kept flags on read
    if (rd_en)
    begin
      if (busy && is_sync_reg(addr))
      begin
        state_next.rdata = 32'h00000000;
      end
      else if (addr == `OFF_CR)
      begin
        state_next.rdata = {11'h000, state_reg.psel, 6'h00,
                            state_reg.ca, 7'h00, state_reg.en};
      end
      else if (addr == `OFF_CV)
      begin
        state_next.rdata = state_reg.cv;
      end
      else if (addr == `OFF_SR)
      begin
        state_next.rdata = sr_view;
      end
      else if (addr == `OFF_IMR)
      begin
        state_next.rdata = state_reg.interrupt_mask_reg;
      end
      else if (addr == `OFF_WER)
      begin
        state_next.rdata = state_reg.wake_enable_reg;
      end
      else if (addr == `OFF_AR0)
      begin
        state_next.rdata = state_reg.ar0;
      end
      else if (addr == `OFF_AR1)
      begin
        state_next.rdata = state_reg.ar1;
      end
      else if (addr == `OFF_PIR0)
      begin
        state_next.rdata = {27'h0000000, state_reg.insel0};
      end
      else if (addr == `OFF_PIR1)
      begin
        state_next.rdata = {27'h0000000, state_reg.insel1};
      end
      else if (addr == `OFF_CLOCK)
      begin
        state_next.rdata = {31'h00000000, state_reg.cen};
      end
      else if (addr == `OFF_DTR)
      begin
        state_next.rdata = {15'h0000, state_reg.dtr_add, 3'h0,
                            state_reg.dtr_exp, state_reg.dtr_val};
      end
      else if (addr == `OFF_EVM)
      begin
        state_next.rdata = state_reg.event_mask_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata        = state_reg.rdata;
  assign irq_ovf      = state_reg.irq[0];
  assign irq_per      = state_reg.irq[1];
  assign irq_alarm    = state_reg.irq[2];
  assign irq_clock_switch_done = state_reg.irq[3];
  assign irq_ready    = state_reg.irq[4];
  assign ev_ovf       = state_reg.ev[0];
  assign ev_periodic_flag_0      = state_reg.ev[1];
  assign ev_periodic_flag_1      = state_reg.ev[2];
  assign ev_alarm_match_flag_0    = state_reg.ev[3];
  assign ev_alarm_match_flag_1    = state_reg.ev[4];
  assign wake_req     = state_reg.wake;

  property p_irq_mask;
    (state_reg.sr[`BIT_OVF] && state_reg.interrupt_mask_reg[`BIT_OVF] && !shutdown_exit &&
     !(wr_en && !busy && addr == `OFF_SCR) &&
     !(wr_en && addr == `OFF_IDR && wdata[`BIT_OVF]))
      |=> irq_ovf;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("overflow request missing");

  property p_ier_set;
    (wr_en && addr == `OFF_IER && wdata[`BIT_ALM0] && !shutdown_exit)
      |=> state_reg.interrupt_mask_reg[`BIT_ALM0];
  endproperty
  a_ier_set: assert property (p_ier_set)
    else $error("enable write did not set mask");

  property p_scr_clear;
    (wr_en && !busy && addr == `OFF_SCR && wdata[`BIT_OVF] && !ovf_set)
      |=> !state_reg.sr[`BIT_OVF];
  endproperty
  a_scr_clear: assert property (p_scr_clear)
    else $error("status clear failed");

  property p_ready_fall;
    $fell(busy) |-> state_reg.sr[`BIT_READY];
  endproperty
  a_ready_fall: assert property (p_ready_fall)
    else $error("ready flag not set on busy fall");

  property p_clkrdy_fall;
    $fell(clock_switch_pending) |-> state_reg.sr[`BIT_CLKRDY];
  endproperty
  a_clkrdy_fall: assert property (p_clkrdy_fall)
    else $error("clock ready flag not set");

  property p_busy_read;
    (busy && rd_en && addr == `OFF_CV) |=> (rdata == 32'h00000000);
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("read during busy not zero");

  property p_shutdown_imr;
    shutdown_exit |=> (state_reg.interrupt_mask_reg == 32'h00000000) && (irq_ovf == 1'b0);
  endproperty
  a_shutdown_imr: assert property (p_shutdown_imr)
    else $error("mask kept after shutdown exit");

  property p_wake;
    (state_reg.sr[`BIT_OVF] && state_reg.wake_enable_reg[`BIT_OVF] &&
     !(wr_en && addr == `OFF_SCR) && !(wr_en && addr == `OFF_WER))
      |=> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake not asserted");

  property p_event;
    (ovf_set && state_reg.event_mask_reg[`BIT_OVF]) |=> ev_ovf ##1 !ev_ovf[*1];
  endproperty
  a_event: assert property (p_event)
    else $error("overflow event wrong");

  property p_clear_alarm;
    (alm_hit[0] && state_reg.ca[0] && !wr_en)
      |=> (state_reg.cv == 32'h00000000) && state_reg.sr[`BIT_OVF];
  endproperty
  a_clear_alarm: assert property (p_clear_alarm)
    else $error("clearing alarm did not reset counter");

endmodule : async_timer_event_wake_tuner
`default_nettype wire

// ===== async_timer_consts.svh
// Constants for the asynchronous timer event, wake and tuner logic
// Functional notes
// - Five separate interrupt request outputs
// - Overflow on wrap or clearing alarm
// - Clock-ready flag on clock-pending falling
// - Ready flag on busy falling
// - Request only when status and mask set
// - Enable sets mask, disable clears mask
// - Request holds until status clear write
// - Periodic flag on chosen prescaler bit rise
// - Periodic rate is source over 2^(sel+1)
// - Alarm flag when counter equals alarm
// - Clearing alarm zeroes counter, sets overflow
// - Events match the status flag conditions
// - Event masks gate events, set/clear writes
// - Wake on enabled sources, ignoring interrupt masks
// - Wake holds until status clear write
// - Shutdown exit clears only interrupt mask
// - Live count and kept flags after shutdown
// - Direction zero drops one increment per period
// - Direction one adds one increment per period
// - Tune value zero disables tuning
// - Busy discards synced writes, reads zero
`ifndef ASYNC_TIMER_CONSTS_SVH
`define ASYNC_TIMER_CONSTS_SVH
`define OFF_CR      8'h00
`define OFF_CV      8'h04
`define OFF_SR      8'h08
`define OFF_SCR     8'h0C
`define OFF_IER     8'h10
`define OFF_IDR     8'h14
`define OFF_IMR     8'h18
`define OFF_WER     8'h1C
`define OFF_AR0     8'h20
`define OFF_AR1     8'h24
`define OFF_PIR0    8'h30
`define OFF_PIR1    8'h34
`define OFF_CLOCK   8'h40
`define OFF_DTR     8'h44
`define OFF_EVE     8'h48
`define OFF_EVD     8'h4C
`define OFF_EVM     8'h50
`define BIT_OVF     0
`define BIT_ALM0    8
`define BIT_ALM1    9
`define BIT_PERIODIC_FLAG_0    16
`define BIT_PERIODIC_FLAG_1    17
`define BIT_BUSY    24
`define BIT_READY   25
`define BIT_CLOCK_SWITCH_PENDING 28
`define BIT_CLKRDY  29
`define CR_EN       0
`define CR_PCLR     1
`define CR_CA0      8
`define CR_CA1      9
`define CR_PSEL_LSB 16
`define CLOCK_CEN   0
`define DTR_ADD     16
`define DTR_EXP_LSB 8
`define SRC_MASK    32'h00030301
`define CLR_MASK    32'h22030301
`define IRQ_MASK    32'h22030301
`define RESET_WORD  32'h00000000
`define CLK_NS      40
`define SYNC_NS     200
`define CLKSW_NS    200
`define SYNC_CYC    ((`SYNC_NS + `CLK_NS - 1) / `CLK_NS)
`define CLKSW_CYC   ((`CLKSW_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== async_timer_pkg.sv
// Types for the asynchronous timer event, wake and tuner logic
package async_timer_pkg;
  typedef struct packed {
    logic        s0;
    logic        s1;
    logic        s2;
    logic        lvl;
    logic [31:0] presc;
    logic [31:0] cv;
    logic        en;
    logic [1:0]  ca;
    logic [4:0]  psel;
    logic        cen;
    logic [3:0]  busy_cnt;
    logic [3:0]  clock_switch_pending_cnt;
    logic [31:0] sr;
    logic [31:0] interrupt_mask_reg;
    logic [31:0] event_mask_reg;
    logic [31:0] wake_enable_reg;
    logic [31:0] ar0;
    logic [31:0] ar1;
    logic [4:0]  insel0;
    logic [4:0]  insel1;
    logic [7:0]  dtr_val;
    logic [4:0]  dtr_exp;
    logic        dtr_add;
    logic [31:0] tune_cnt;
    logic [31:0] rdata;
    logic [4:0]  irq;
    logic [4:0]  ev;
    logic        wake;
  } timer_state_t;
endpackage : async_timer_pkg

// ===== prsc_source_model.sv
// Prescaler source clock stand-in for the timer bench
`timescale 1ns/100ps
`default_nettype none
module prsc_source_model
(
  // Control from bench
  input  wire logic run,
  // Toward the timer
  output var  logic pin
);
  // Phase unrelated to clk_sys; stands low while stopped
  initial
  begin
    pin = 1'b0;
    forever
    begin
      #165;
      pin = run ? ~pin : 1'b0;
    end
  end
endmodule : prsc_source_model
`default_nettype wire

// ===== async_timer_event_wake_tuner_test.sv
// Self-checking bench for the timer event, wake and tuner logic
`timescale 1ns/100ps
`default_nettype none
`include "async_timer_consts.svh"
`define CHK(got, exp) \
  begin compares++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module async_timer_event_wake_tuner_test
  import async_timer_pkg::*;
;
  logic        clk_sys;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata;
  logic        prsc_run;
  logic        prsc_clk_pin;
  logic        shutdown_exit;
  logic        irq_ovf;
  logic        irq_per;
  logic        irq_alarm;
  logic        irq_clock_switch_done;
  logic        irq_ready;
  logic        ev_ovf;
  logic        ev_periodic_flag_0;
  logic        ev_periodic_flag_1;
  logic        ev_alarm_match_flag_0;
  logic        ev_alarm_match_flag_1;
  logic        wake_req;
  int          errors;
  int          compares;
  int          cycles;
  int          dt;
  realtime     t0;
  logic [31:0] seed;
  logic [31:0] rv;
  logic [31:0] imr_m;
  logic [31:0] evm_m;
  logic [4:0]  seen;
  logic        periodic_flag_1_seen;

  async_timer_event_wake_tuner dut (
    .clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .prsc_clk_pin(prsc_clk_pin), .shutdown_exit(shutdown_exit),
    .irq_ovf(irq_ovf), .irq_per(irq_per), .irq_alarm(irq_alarm),
    .irq_clock_switch_done(irq_clock_switch_done), .irq_ready(irq_ready),
    .ev_ovf(ev_ovf), .ev_periodic_flag_0(ev_periodic_flag_0), .ev_periodic_flag_1(ev_periodic_flag_1),
    .ev_alarm_match_flag_0(ev_alarm_match_flag_0), .ev_alarm_match_flag_1(ev_alarm_match_flag_1), .wake_req(wake_req)
  );

  prsc_source_model src (
    .run(prsc_run),
    .pin(prsc_clk_pin)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever
      #20 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  task automatic tally_and_finish();
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  task automatic wr_sync(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    repeat (8) @(posedge clk_sys);
  endtask : wr_sync

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic wait_ev(input logic [4:0] m, output logic [4:0] s);
    s = 5'h00;
    for (int i = 0; i < 400 && (s & m) == 5'h00; i++)
    begin
      @(posedge clk_sys);
      #1 s = {ev_alarm_match_flag_1, ev_alarm_match_flag_0, ev_periodic_flag_1, ev_periodic_flag_0, ev_ovf};
    end
  endtask : wait_ev

  // Time across three periodic 0 intervals
  task automatic per_span(output int d);
    logic [4:0] s;
    wait_ev(5'b00010, s);
    t0 = $realtime;
    repeat (3)
    begin
      @(posedge clk_sys);
      wait_ev(5'b00010, s);
    end
    d = int'(($realtime - t0) / 40.0);
  endtask : per_span

  always @(posedge clk_sys)
  begin
    cycles++;
    if (ev_periodic_flag_1 === 1'b1)
      periodic_flag_1_seen = 1'b1;
    if (cycles == 20000)
    begin
      errors++;
      $display("[ERR] %0t run timed out", $time);
      tally_and_finish();
    end
  end

  initial
  begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    prsc_run = 1'b0;
    shutdown_exit = 1'b0;
    errors = 0;
    compares = 0;
    cycles = 0;
    periodic_flag_1_seen = 1'b0;
    seed = 32'h4E0D;
    imr_m = 32'h0000_0000;
    evm_m = 32'h0000_0000;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`OFF_IMR, rv);
    `CHK(rv, 32'h0000_0000)
    rd(8'hEC, rv);
    `CHK(rv, 32'h0000_0000)
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      if (seed[0])
      begin
        wr(`OFF_IER, seed);
        imr_m = imr_m | (seed & `IRQ_MASK);
      end
      else
      begin
        wr(`OFF_IDR, seed);
        imr_m = imr_m & ~seed;
      end
      rd(`OFF_IMR, rv);
      `CHK(rv, imr_m & `IRQ_MASK)
    end
    wr(`OFF_IDR, 32'hFFFF_FFFF);
    wr(`OFF_IER, 32'h1 << `BIT_READY);
    wr(`OFF_AR0, 32'h0000_0003);
    wr(`OFF_AR1, 32'h0000_0005);
    rd(`OFF_SR, rv);
    `CHK(rv[`BIT_BUSY], 1'b1)
    repeat (8) @(posedge clk_sys);
    #1 `CHK(irq_ready, 1'b1)
    wr(`OFF_IDR, 32'h1 << `BIT_READY);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(irq_ready, 1'b0)
    rd(`OFF_AR0, rv);
    `CHK(rv, 32'h0000_0003)
    rd(`OFF_AR1, rv);
    `CHK(rv, 32'h0000_0000)
    wr(`OFF_IER, 32'h1 << `BIT_CLKRDY);
    wr(`OFF_CLOCK, 32'h1);
    repeat (8) @(posedge clk_sys);
    #1 `CHK(irq_clock_switch_done, 1'b1)
    wr(`OFF_WER, 32'h1 << `BIT_OVF);
    rd(`OFF_AR0, rv);
    `CHK(rv, 32'h0000_0000)
    repeat (8) @(posedge clk_sys);
    wr_sync(`OFF_EVE, `SRC_MASK);
    wr_sync(`OFF_EVD, 32'h1 << `BIT_PERIODIC_FLAG_1);
    evm_m = `SRC_MASK & ~(32'h1 << `BIT_PERIODIC_FLAG_1);
    // interval and alarm set before the timer runs
    wr_sync(`OFF_PIR0, 32'h1);
    wr(`OFF_IER, 32'h1 << `BIT_OVF);
    wr_sync(`OFF_CR, (32'h1 << `CR_EN) | (32'h1 << `CR_CA0));
    prsc_run <= 1'b1;
    wait_ev(5'b01000, seen);
    `CHK(seen[3], 1'b1)
    `CHK(seen[0], 1'b1)
    repeat (2) @(posedge clk_sys);
    #1 `CHK(irq_ovf, 1'b1)
    `CHK(irq_alarm, 1'b0)
    `CHK(wake_req, 1'b1)
    rd(`OFF_CV, rv);
    `CHK(rv < 32'h2, 1'b1)
    wait_ev(5'b00010, seen);
    `CHK(seen[1], 1'b1)
    t0 = $realtime;
    @(posedge clk_sys);
    wait_ev(5'b00010, seen);
    dt = int'(($realtime - t0) / 40.0);
    `CHK(dt >= 32 && dt <= 34, 1'b1)
    // value 128, exponent 1: tuner period of four ticks
    wr_sync(`OFF_DTR, (32'h1 << `DTR_EXP_LSB) | 32'h0000_0080);
    per_span(dt);
    // Twelve increments need fifteen to seventeen ticks
    `CHK(dt >= 120 && dt <= 142, 1'b1)
    wr_sync(`OFF_DTR, (32'h1 << `DTR_ADD) | (32'h1 << `DTR_EXP_LSB) |
            32'h0000_0080);
    per_span(dt);
    // Twelve increments need nine to eleven ticks
    `CHK(dt >= 70 && dt <= 94, 1'b1)
    prsc_run <= 1'b0;
    repeat (20) @(posedge clk_sys);
    wr(`OFF_IER, 32'h1 << `BIT_PERIODIC_FLAG_0);
    repeat (2) @(posedge clk_sys);
    #1 `CHK(irq_per, 1'b1)
    wr_sync(`OFF_SCR, 32'h1 << `BIT_OVF);
    #1 `CHK(irq_ovf, 1'b0)
    `CHK(wake_req, 1'b0)
    `CHK(periodic_flag_1_seen, 1'b0)
    @(posedge clk_sys);
    shutdown_exit <= 1'b1;
    @(posedge clk_sys);
    shutdown_exit <= 1'b0;
    rd(`OFF_IMR, rv);
    `CHK(rv, 32'h0000_0000)
    rd(`OFF_EVM, rv);
    `CHK(rv, evm_m)
    rd(`OFF_WER, rv);
    `CHK(rv, 32'h1 << `BIT_OVF)
    rd(`OFF_SR, rv);
    `CHK(rv[`BIT_PERIODIC_FLAG_0], 1'b1)
    #1 `CHK(irq_per, 1'b0)
    tally_and_finish();
  end
endmodule : async_timer_event_wake_tuner_test
`default_nettype wire
